// *** hdl/spc_pin_ctrl.sv ***
// serial port pin, clock and frame-sync routing with its control registers
// Operation
// [RULE1] tx frame-sync source bit 0: tx frame sync comes from the tx frame-sync pin.
// [RULE2] source bit 1: tx frame sync follows the generator frame-sync mode bit.
// [RULE3] rx frame-sync source bit 0: rx frame-sync pin is input, partner drives it.
// [RULE4] source bit 1: generator makes rx sync; pin driven unless external sync.
// [RULE5] non-SPI, tx clock source 0: tx clock pin is input, external clock.
// [RULE6] non-SPI, tx clock source 1: drive tx clock pin from generator.
// [RULE7] SPI slave: master drives tx clock pin, rx clock follows it.
// [RULE8] SPI master: generate tx clock, use as rx clock, drive it out.
// [RULE9] no loopback, rx clock source 0: rx clock pin input, external clock.
// [RULE10] no loopback, rx clock source 1: drive rx clock pin from generator.
// [RULE11] loopback, rx source 0: rx clock is tx clock, rx pin undriven.
// [RULE12] loopback, rx source 1: drive rx clock pin with the tx clock.
// [RULE13] bit 6 reads external clock pin level when it is a general input.
// [RULE14] bit 5 holds the level driven on tx data pin as general output.
// [RULE15] bit 4 reads rx data pin level when it is a general input.
// [RULE16] bit 3 selects tx frame sync active high (0) or low (1).
// [RULE17] bit 2 selects rx frame sync active high (0) or low (1).
// [RULE18] bit 1 times tx data to rising (0) or falling (1) tx clock edge.
// [RULE19] bit 0 samples rx data on falling (0) or rising (1) rx clock edge.
// [RULE20] reserved bits, bit 7 among them, store nothing and read zero.
// [RULE21] polarities applied at pins; inside, sync is high and clock edge fixed.
`timescale 1ns/10ps
module spc_pin_ctrl
	import spc_pkg::*;
(
	input  wire logic              clk,            // core clock, 40 MHz
	input  wire logic              reset,          // async reset, active high
	input  wire logic [ADDR_W-1:0] regAddr,        // register address
	input  wire logic [DATA_W-1:0] regWdata,       // register write data
	input  wire logic              regWr,          // write strobe
	input  wire logic              regRd,          // read strobe
	output logic      [DATA_W-1:0] regRdata,       // read data, cycle after strobe
	input  wire logic              genClk,         // rate generator clock level
	input  wire logic              genFsync,       // rate generator frame sync
	input  wire logic              txCopyFsync,    // frame sync from transmit copy
	input  wire logic              txData,         // serial transmit bit
	input  wire logic              txDataEn,       // transmitter drives data pin
	input  wire logic              txClockPinIn,   // tx clock pin level
	output logic                   txClockPinOut,  // tx clock pin drive
	output logic                   txClockPinOe,   // tx clock pin enable
	input  wire logic              rxClockPinIn,   // rx clock pin level
	output logic                   rxClockPinOut,  // rx clock pin drive
	output logic                   rxClockPinOe,   // rx clock pin enable
	input  wire logic              txFsyncPinIn,   // tx frame-sync pin level
	output logic                   txFsyncPinOut,  // tx frame-sync pin drive
	output logic                   txFsyncPinOe,   // tx frame-sync pin enable
	input  wire logic              rxFsyncPinIn,   // rx frame-sync pin level
	output logic                   rxFsyncPinOut,  // rx frame-sync pin drive
	output logic                   rxFsyncPinOe,   // rx frame-sync pin enable
	input  wire logic              extClockPinIn,  // external clock pin level
	output logic                   txDataPinOut,   // tx data pin drive
	output logic                   txDataPinOe,    // tx data pin enable
	input  wire logic              rxDataPinIn,    // rx data pin level
	output logic                   rxDataLevel,    // synchronised rx data
	output logic                   rxFsyncPinLevel,// rx frame-sync pin, active high
	output logic                   txClkInt,       // internal tx clock
	output logic                   rxClkInt,       // internal rx clock
	output logic                   txFsyncInt,     // tx frame sync, active high
	output logic                   rxFsyncInt,     // rx frame sync, active high
	output logic                   txShiftStrobe,  // one cycle at tx active edge
	output logic                   rxSampleStrobe  // one cycle at rx active edge
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	spc_pin_if pins ();

	assign pins.raw[SYNC_TX_CLK]  = txClockPinIn;
	assign pins.raw[SYNC_RX_CLK]  = rxClockPinIn;
	assign pins.raw[SYNC_TX_FS]   = txFsyncPinIn;
	assign pins.raw[SYNC_RX_FS]   = rxFsyncPinIn;
	assign pins.raw[SYNC_EXT_CLK] = extClockPinIn;
	assign pins.raw[SYNC_RX_DATA] = rxDataPinIn;

	spc_pin_sync u_sync (
		.clk   (clk),
		.reset (reset),
		.pins  (pins)
	);

	wire txClkLvl = pins.lvl[SYNC_TX_CLK];
	wire rxClkLvl = pins.lvl[SYNC_RX_CLK];
	wire txFsLvl  = pins.lvl[SYNC_TX_FS];
	wire rxFsLvl  = pins.lvl[SYNC_RX_FS];
	wire extLvl   = pins.lvl[SYNC_EXT_CLK];
	wire rxdLvl   = pins.lvl[SYNC_RX_DATA];

	// ****************************************
	// register bus
	// ****************************************
	logic [DATA_W-1:0] pinQ;
	logic [DATA_W-1:0] auxQ;
	logic [DATA_W-1:0] rdata_q;

	wire pinWr = regWr && (regAddr == ADDR_PIN_CTRL);
	wire auxWr = regWr && (regAddr == ADDR_AUX_CTRL);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pinQ <= PIN_RST;
			auxQ <= AUX_RST;
		end
		else
		begin
			if (pinWr)
				pinQ <= regWdata & PIN_RW_MASK; // see [RULE20]
			if (auxWr)
				auxQ <= regWdata & AUX_RW_MASK;
		end
	end

	// ****************************************
	// field decode
	// ****************************************
	wire txFsSrc   = pinQ[BIT_TX_FS_SRC];
	wire rxFsSrc   = pinQ[BIT_RX_FS_SRC];
	wire txClkSel  = pinQ[BIT_TX_CLK_SRC];
	wire rxClkSel  = pinQ[BIT_RX_CLK_SRC];
	wire txFsPol   = pinQ[BIT_TX_FS_POL];
	wire rxFsPol   = pinQ[BIT_RX_FS_POL];
	wire txClkPol  = pinQ[BIT_TX_CLK_POL];
	wire rxClkPol  = pinQ[BIT_RX_CLK_POL];
	wire spiMode   = auxQ[AUX_CLK_STOP_HI] || auxQ[AUX_CLK_STOP_LO];
	wire loopback  = auxQ[AUX_LOOPBACK];
	wire genExtSyn = auxQ[AUX_GEN_EXT_SYNC];
	wire genFsMode = auxQ[AUX_GEN_FS_MODE];
	wire txGpio    = auxQ[AUX_TX_GPIO];
	wire rxGpio    = auxQ[AUX_RX_GPIO];

	// ****************************************
	// read path
	// ****************************************
	wire extGp = rxGpio && extLvl; // see [RULE13]
	wire rxdGp = rxGpio && rxdLvl; // see [RULE15]

	wire [DATA_W-1:0] pinStatus = ({15'h0000, extGp} << BIT_EXT_CLK_LVL)
		| ({15'h0000, rxdGp} << BIT_RX_DATA_LVL);
	wire [DATA_W-1:0] pinRead   = (pinQ & PIN_RW_MASK) | pinStatus; // see [RULE20]
	wire [DATA_W-1:0] readMux   = (regAddr == ADDR_PIN_CTRL) ? pinRead
		: (regAddr == ADDR_AUX_CTRL) ? (auxQ & AUX_RW_MASK) : RD_IDLE;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			rdata_q <= RD_IDLE;
		else
			rdata_q <= regRd ? readMux : RD_IDLE;
	end

	assign regRdata = rdata_q;

	// ****************************************
	// frame-sync routing
	// ****************************************
	wire txFsGen  = genFsMode ? genFsync : txCopyFsync;                 // see [RULE2]
	wire txFsSel  = txFsSrc ? txFsGen : (txFsLvl ^ txFsPol);           // see [RULE1], [RULE16]
	wire rxFsSel  = rxFsSrc ? genFsync : (rxFsLvl ^ rxFsPol);          // see [RULE4], [RULE17]
	wire txFsOe   = txFsSrc;
	wire rxFsOe   = rxFsSrc && !genExtSyn;                              // see [RULE3], [RULE4]

	// ****************************************
	// clock routing
	// ****************************************
	wire txSrc     = txClkSel ? genClk : txClkLvl;                      // see [RULE5], [RULE6]
	wire rxFollow  = loopback || spiMode;                               // see [RULE7], [RULE8]
	wire rxSrc     = rxFollow ? txSrc : (rxClkSel ? genClk : rxClkLvl); // see [RULE9], [RULE11]
	wire rxPinDrv  = rxFollow ? txSrc : genClk;                         // see [RULE10], [RULE12]
	// internal active edge is always the rising one
	wire txClkD    = txSrc ^ txClkPol;                                  // see [RULE18], [RULE21]
	wire rxClkD    = rxSrc ^ !rxClkPol;                                 // see [RULE19], [RULE21]
	wire txDataDrv = txGpio ? pinQ[BIT_TX_DATA_LVL] : txData;           // see [RULE14]
	wire txDataEnD = txGpio || txDataEn;

	// ****************************************
	// pin drivers
	// ****************************************
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			txFsyncPinOut <= 1'b0;
			txFsyncPinOe  <= 1'b0;
			rxFsyncPinOut <= 1'b0;
			rxFsyncPinOe  <= 1'b0;
		end
		else
		begin
			txFsyncPinOut <= txFsGen ^ txFsPol;  // see [RULE16]
			txFsyncPinOe  <= txFsOe;
			rxFsyncPinOut <= genFsync ^ rxFsPol; // see [RULE17]
			rxFsyncPinOe  <= rxFsOe;             // see [RULE4]
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			txClockPinOut <= 1'b0;
			txClockPinOe  <= 1'b0;
			rxClockPinOut <= 1'b0;
			rxClockPinOe  <= 1'b0;
		end
		else
		begin
			txClockPinOut <= genClk;
			txClockPinOe  <= txClkSel; // see [RULE6], [RULE8]
			rxClockPinOut <= rxPinDrv;
			rxClockPinOe  <= rxClkSel; // see [RULE10], [RULE11]
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			txDataPinOut    <= 1'b0;
			txDataPinOe     <= 1'b0;
			rxDataLevel     <= 1'b0;
			rxFsyncPinLevel <= 1'b0;
		end
		else
		begin
			txDataPinOut    <= txDataDrv;
			txDataPinOe     <= txDataEnD;
			rxDataLevel     <= rxdLvl;
			rxFsyncPinLevel <= rxFsLvl ^ rxFsPol;
		end
	end

	// ****************************************
	// internal clocks, syncs and edge strobes
	// ****************************************
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			txClkInt   <= 1'b0;
			rxClkInt   <= 1'b1; // idle low pin reads high inside at reset polarity
			txFsyncInt <= 1'b0;
			rxFsyncInt <= 1'b0;
		end
		else
		begin
			txClkInt   <= txClkD;
			rxClkInt   <= rxClkD;
			txFsyncInt <= txFsSel;
			rxFsyncInt <= rxFsSel;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			txShiftStrobe  <= 1'b0;
			rxSampleStrobe <= 1'b0;
		end
		else
		begin
			txShiftStrobe  <= txClkD && !txClkInt; // see [RULE18]
			rxSampleStrobe <= rxClkD && !rxClkInt; // see [RULE19]
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_cfgQuiet;
		!regWr ##1 !regWr;
	endsequence

	property p_r1;
		s_cfgQuiet ##0 !txFsSrc |=> txFsyncInt == $past(txFsLvl ^ txFsPol);
	endproperty
	a_r1: assert property (p_r1) else $error("tx sync not from pin"); // see [RULE1]

	property p_r2;
		s_cfgQuiet ##0 txFsSrc |=>
			txFsyncInt == $past(genFsMode ? genFsync : txCopyFsync);
	endproperty
	a_r2: assert property (p_r2) else $error("tx sync not from generator"); // see [RULE2]

	property p_r3;
		pinWr && !regWdata[BIT_RX_FS_SRC] |=> ##1 !rxFsyncPinOe;
	endproperty
	a_r3: assert property (p_r3) else $error("rx sync pin driven as input"); // see [RULE3]

	property p_r4;
		pinWr && regWdata[BIT_RX_FS_SRC] ##1 !regWr && !genExtSyn
			|=> rxFsyncPinOe && rxFsyncInt == $past(genFsync);
	endproperty
	a_r4: assert property (p_r4) else $error("rx sync pin not driven"); // see [RULE4]

	property p_r5;
		pinWr && !regWdata[BIT_TX_CLK_SRC] |=> ##1 !txClockPinOe;
	endproperty
	a_r5: assert property (p_r5) else $error("tx clock pin driven as input"); // see [RULE5]

	property p_r6;
		txClkSel && !regWr |=> txClockPinOe && txClockPinOut == $past(genClk);
	endproperty
	a_r6: assert property (p_r6) else $error("tx clock pin not from generator"); // see [RULE6]

	property p_r8;
		s_cfgQuiet ##0 spiMode && txClkSel
			|=> txClockPinOe && rxClkInt == $past(genClk ^ !rxClkPol);
	endproperty
	a_r8: assert property (p_r8) else $error("spi rx clock not tx clock"); // see [RULE8]

	property p_r7;
		s_cfgQuiet ##0 spiMode && !txClkSel |=> rxClkInt == $past(txClkLvl ^ !rxClkPol);
	endproperty
	a_r7: assert property (p_r7) else $error("spi slave clock not from pin"); // see [RULE7]

	property p_r9;
		s_cfgQuiet ##0 !rxFollow && !rxClkSel
			|=> !rxClockPinOe && rxClkInt == $past(rxClkLvl ^ !rxClkPol);
	endproperty
	a_r9: assert property (p_r9) else $error("rx clock not from pin"); // see [RULE9]

	property p_r10;
		!regWr && !rxFollow && rxClkSel |=> rxClockPinOe && rxClockPinOut == $past(genClk);
	endproperty
	a_r10: assert property (p_r10) else $error("rx clock pin not from generator"); // see [RULE10]

	property p_r11;
		s_cfgQuiet ##0 loopback && !rxClkSel
			|=> !rxClockPinOe && rxClkInt == $past(txSrc ^ !rxClkPol);
	endproperty
	a_r11: assert property (p_r11) else $error("loopback rx clock wrong"); // see [RULE11]

	property p_r12;
		!regWr && loopback && rxClkSel |=> rxClockPinOe && rxClockPinOut == $past(txSrc);
	endproperty
	a_r12: assert property (p_r12) else $error("loopback rx pin not tx clock"); // see [RULE12]

	property p_r13;
		regRd && regAddr == ADDR_PIN_CTRL
			|=> regRdata[BIT_EXT_CLK_LVL] == $past(rxGpio && extLvl);
	endproperty
	a_r13: assert property (p_r13) else $error("ext clock status wrong"); // see [RULE13]

	property p_r14;
		pinWr && regWdata[BIT_TX_DATA_LVL] ##1 (txGpio && !regWr) |=> txDataPinOut && txDataPinOe;
	endproperty
	a_r14: assert property (p_r14) else $error("gpio tx data level lost"); // see [RULE14]

	property p_r15;
		regRd && regAddr == ADDR_PIN_CTRL
			|=> regRdata[BIT_RX_DATA_LVL] == $past(rxGpio && rxdLvl);
	endproperty
	a_r15: assert property (p_r15) else $error("rx data status wrong"); // see [RULE15]

	property p_r16;
		s_cfgQuiet ##0 !txFsSrc && txFsPol |=> txFsyncInt == !$past(txFsLvl);
	endproperty
	a_r16: assert property (p_r16) else $error("tx sync polarity wrong"); // see [RULE16]

	property p_r17;
		s_cfgQuiet ##0 !rxFsSrc && rxFsPol |=> rxFsyncInt == !$past(rxFsLvl);
	endproperty
	a_r17: assert property (p_r17) else $error("rx sync polarity wrong"); // see [RULE17]

	property p_r18;
		s_cfgQuiet ##0 $rose(txSrc) && !txClkPol |=> txShiftStrobe;
	endproperty
	a_r18: assert property (p_r18) else $error("tx edge strobe missing"); // see [RULE18]

	property p_r19;
		s_cfgQuiet ##0 $fell(rxSrc) && !rxClkPol |=> rxSampleStrobe;
	endproperty
	a_r19: assert property (p_r19) else $error("rx edge strobe missing"); // see [RULE19]

	property p_r20;
		regRd |=> regRdata[15:12] == 4'h0 && !regRdata[7];
	endproperty
	a_r20: assert property (p_r20) else $error("reserved bits read nonzero"); // see [RULE20]

	property p_r21;
		txShiftStrobe |-> $past(txSrc ^ txClkPol) && !$past(txSrc ^ txClkPol, 2);
	endproperty
	a_r21: assert property (p_r21) else $error("tx strobe not on rising edge"); // see [RULE21]

endmodule // spc_pin_ctrl

// *** hdl/spc_pin_if.sv ***
// raw and synchronised pin levels between core and synchroniser
`timescale 1ns/10ps
interface spc_pin_if;
	import spc_pkg::*;
	logic [N_SYNC-1:0] raw;
	logic [N_SYNC-1:0] lvl;
	modport sync (input raw, output lvl);
	modport core (output raw, input lvl);
endinterface

// *** hdl/spc_pin_sync.sv ***
// two-stage synchronisers for the serial port input pins
`timescale 1ns/10ps
module spc_pin_sync
	import spc_pkg::*;
(
	input  wire logic clk,    // core clock
	input  wire logic reset,  // async reset, active high
	spc_pin_if.sync   pins    // raw pins in, levels out
);

	logic [N_SYNC-1:0] stage1_q;
	logic [N_SYNC-1:0] stage2_q;

	// ****************************************
	// one synchroniser per pin
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < N_SYNC; i++)
		begin : g_sync
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
				begin
					stage1_q[i] <= 1'b0;
					stage2_q[i] <= 1'b0;
				end
				else
				begin
					stage1_q[i] <= pins.raw[i];
					stage2_q[i] <= stage1_q[i];
				end
			end
		end
	endgenerate

	assign pins.lvl = stage2_q;

endmodule // spc_pin_sync

// *** hdl/spc_pkg.sv ***
// constants shared by the serial pin control block
package spc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int              ADDR_W        = 4;
	localparam int              DATA_W        = 16;
	localparam logic [3:0]      ADDR_PIN_CTRL = 4'h0;
	localparam logic [3:0]      ADDR_AUX_CTRL = 4'h1;
	localparam logic [15:0]     PIN_RST       = 16'h0000;
	localparam logic [15:0]     AUX_RST       = 16'h0000;
	localparam logic [15:0]     RD_IDLE       = 16'h0000;
	// writable bits of the pin control register: 11..8, 5, 3..0
	localparam logic [15:0]     PIN_RW_MASK   = 16'h0f2f;
	localparam logic [15:0]     AUX_RW_MASK   = 16'h007f;

	// ****************************************
	// pin control fields
	// ****************************************
	localparam int BIT_RX_CLK_POL   = 0;
	localparam int BIT_TX_CLK_POL   = 1;
	localparam int BIT_RX_FS_POL    = 2;
	localparam int BIT_TX_FS_POL    = 3;
	localparam int BIT_RX_DATA_LVL  = 4;
	localparam int BIT_TX_DATA_LVL  = 5;
	localparam int BIT_EXT_CLK_LVL  = 6;
	localparam int BIT_RX_CLK_SRC   = 8;
	localparam int BIT_TX_CLK_SRC   = 9;
	localparam int BIT_RX_FS_SRC    = 10;
	localparam int BIT_TX_FS_SRC    = 11;

	// ****************************************
	// auxiliary control fields
	// ****************************************
	localparam int AUX_CLK_STOP_LO  = 0;
	localparam int AUX_CLK_STOP_HI  = 1;
	localparam int AUX_LOOPBACK     = 2;
	localparam int AUX_GEN_EXT_SYNC = 3;
	localparam int AUX_GEN_FS_MODE  = 4;
	localparam int AUX_TX_GPIO      = 5;
	localparam int AUX_RX_GPIO      = 6;

	// ****************************************
	// synchronised pin indices
	// ****************************************
	localparam int N_SYNC           = 6;
	localparam int SYNC_TX_CLK      = 0;
	localparam int SYNC_RX_CLK      = 1;
	localparam int SYNC_TX_FS       = 2;
	localparam int SYNC_RX_FS       = 3;
	localparam int SYNC_EXT_CLK     = 4;
	localparam int SYNC_RX_DATA     = 5;

endpackage

// *** testbench/spc_partner.sv ***
// external codec model: bit clocks, frame syncs, data and clock pins
`timescale 1ns/10ps
module spc_partner
(
	input  wire logic runTx,    // tx bit clock runs
	input  wire logic runRx,    // rx bit clock runs
	input  wire logic fsTx,     // tx frame-sync level
	input  wire logic fsRx,     // rx frame-sync level
	input  wire logic extLvl,   // external clock pin level
	input  wire logic dataLvl,  // rx data level
	output logic      clkTx,    // tx clock pin drive
	output logic      clkRx,    // rx clock pin drive
	output logic      fsTxPin,  // tx frame-sync pin drive
	output logic      fsRxPin,  // rx frame-sync pin drive
	output logic      extPin,   // external clock pin drive
	output logic      dataPin   // rx data pin drive
);
	logic bitClk;
	initial
	begin
		bitClk = 1'b0;
		#7;
		forever #100 bitClk = ~bitClk;
	end
	// clocks stand still low outside frames
	assign clkTx   = runTx & bitClk;
	assign clkRx   = runRx & bitClk;
	assign fsTxPin = fsTx;
	assign fsRxPin = fsRx;
	assign extPin  = extLvl;
	assign dataPin = dataLvl;
endmodule // spc_partner

// *** testbench/testbench.sv ***
// self-checking bench for the serial pin control block
`timescale 1ns/10ps
module testbench;
	import spc_pkg::*;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWdata, regRdata;
	logic clk, reset, regWr, regRd, genClk, genFsync, txCopyFsync, txData, txDataEn;
	logic runTx, runRx, fsTx, fsRx, extLvl, dataLvl, genRun, edgeChk, txPol, rxPol;
	logic txCkOut, txCkOe, rxCkOut, rxCkOe, txFsOut, txFsOe, rxFsOut, rxFsOe, txDOut;
	logic txDOe, txClkInt, rxClkInt, txFsyncInt, rxFsyncInt, txStb, rxStb, prevTx, prevRx;
	logic rxDLv, rxFsLv;
	wire  pClkTx, pClkRx, pFsTx, pFsRx, pExt, pData;
	wire  txClkW = txCkOe ? txCkOut : pClkTx;
	wire  rxClkW = rxCkOe ? rxCkOut : pClkRx;
	wire  txFsW  = txFsOe ? txFsOut : pFsTx;
	wire  rxFsW  = rxFsOe ? rxFsOut : pFsRx;
	int   n_fail, cmp_count, cyc, txRise, txFall, rxRise, rxFall, txCnt, rxCnt, gDiv, tc, rc;

	spc_partner u_spc_partner (.runTx(runTx), .runRx(runRx), .fsTx(fsTx), .fsRx(fsRx),
		.extLvl(extLvl), .dataLvl(dataLvl), .clkTx(pClkTx), .clkRx(pClkRx),
		.fsTxPin(pFsTx), .fsRxPin(pFsRx), .extPin(pExt), .dataPin(pData));

	spc_pin_ctrl u_spc_pin_ctrl (.clk(clk), .reset(reset), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.genClk(genClk), .genFsync(genFsync), .txCopyFsync(txCopyFsync), .txData(txData),
		.txDataEn(txDataEn), .txClockPinIn(txClkW), .txClockPinOut(txCkOut),
		.txClockPinOe(txCkOe), .rxClockPinIn(rxClkW), .rxClockPinOut(rxCkOut),
		.rxClockPinOe(rxCkOe), .txFsyncPinIn(txFsW), .txFsyncPinOut(txFsOut),
		.txFsyncPinOe(txFsOe), .rxFsyncPinIn(rxFsW), .rxFsyncPinOut(rxFsOut),
		.rxFsyncPinOe(rxFsOe), .extClockPinIn(pExt), .txDataPinOut(txDOut),
		.txDataPinOe(txDOe), .rxDataPinIn(pData), .rxDataLevel(rxDLv),
		.rxFsyncPinLevel(rxFsLv),
		.txClkInt(txClkInt), .rxClkInt(rxClkInt), .txFsyncInt(txFsyncInt),
		.rxFsyncInt(rxFsyncInt), .txShiftStrobe(txStb), .rxSampleStrobe(rxStb));

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e)
		begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic inr(input int v, input int lo, input int hi);
		chk(16'(v >= lo && v <= hi), 16'h0001);
	endtask
	task st(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task cfg(input logic [15:0] p, input logic [15:0] x);
		wr(ADDR_PIN_CTRL, p);
		wr(ADDR_AUX_CTRL, x);
		st(5);
	endtask
	task rdc(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		chk(regRdata, e);
	endtask
	task win(input int n);
		int a;
		int b;
		a = txCnt;
		b = rxCnt;
		st(n);
		tc = txCnt - a;
		rc = rxCnt - b;
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// generator clock, period of ten core cycles
	always @(posedge clk)
		if (genRun)
		begin
			gDiv <= (gDiv == 4) ? 0 : gDiv + 1;
			if (gDiv == 4)
				genClk <= ~genClk;
		end

	// pin edge monitor, strobe counters, timeout
	always @(posedge clk)
	begin
		cyc    <= cyc + 1;
		prevTx <= txClkW;
		prevRx <= rxClkW;
		if (txClkW && !prevTx) txRise <= cyc;
		if (!txClkW && prevTx) txFall <= cyc;
		if (rxClkW && !prevRx) rxRise <= cyc;
		if (!rxClkW && prevRx) rxFall <= cyc;
		if (txStb === 1'b1) txCnt <= txCnt + 1;
		if (rxStb === 1'b1) rxCnt <= rxCnt + 1;
		if (edgeChk && txStb === 1'b1) inr(cyc - (txPol ? txFall : txRise), 2, 5);
		if (edgeChk && rxStb === 1'b1) inr(cyc - (rxPol ? rxRise : rxFall), 2, 5);
		if (cyc == 12000)
		begin
			n_fail++;
			test_done;
		end
	end

	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		int m;
		{regAddr, regWdata, regWr, regRd, genClk, genFsync, txCopyFsync} = '0;
		{txData, txDataEn, runTx, runRx, fsTx, fsRx, extLvl, dataLvl} = '0;
		{genRun, edgeChk, txPol, rxPol, prevTx, prevRx} = '0;
		{n_fail, cmp_count, cyc, txRise, txFall, rxRise, rxFall, txCnt, rxCnt, gDiv} = '0;
		reset = 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		st(1);
		chk({12'h000, txCkOe, rxCkOe, txFsOe, rxFsOe}, 16'h0000);
		rdc(ADDR_PIN_CTRL, PIN_RST);
		rdc(ADDR_AUX_CTRL, AUX_RST);
		st(1);
		chk(regRdata, RD_IDLE);
		rdc(4'h7, RD_IDLE);
		$display("test reset done");
		wr(ADDR_AUX_CTRL, 16'hffff);
		rdc(ADDR_AUX_CTRL, AUX_RW_MASK);
		wr(ADDR_PIN_CTRL, 16'hffff);
		rdc(ADDR_PIN_CTRL, 16'h0f2f);
		wr(4'h7, 16'h0000);
		rdc(ADDR_PIN_CTRL, 16'h0f2f);
		extLvl  = 1'b1;
		dataLvl = 1'b1;
		cfg(16'h0000, 16'h0040);
		rdc(ADDR_PIN_CTRL, 16'h0050);
		extLvl = 1'b0;
		st(4);
		rdc(ADDR_PIN_CTRL, 16'h0010);
		$display("test registers done");
		@(posedge clk);
		txData   <= 1'b1;
		txDataEn <= 1'b1;
		cfg(16'h0000, 16'h0020);
		chk({14'h0000, txDOut, txDOe}, 16'h0001);
		cfg(16'h0020, 16'h0020);
		chk({14'h0000, txDOut, txDOe}, 16'h0003);
		rdc(ADDR_PIN_CTRL, 16'h0020);
		$display("test data pin done");
		fsTx = 1'b1;
		fsRx = 1'b1;
		cfg(16'h0000, 16'h0000);
		chk({14'h0000, txDOut, txDOe}, 16'h0003);
		chk({12'h000, txFsyncInt, rxFsyncInt, rxFsOe, rxDLv}, 16'h000d);
		cfg(16'h000c, 16'h0000);
		chk({13'h0000, txFsyncInt, rxFsyncInt, rxFsLv}, 16'h0000);
		fsTx = 1'b0;
		fsRx = 1'b0;
		st(4);
		chk({13'h0000, txFsyncInt, rxFsyncInt, rxFsLv}, 16'h0007);
		@(posedge clk);
		genFsync <= 1'b1;
		cfg(16'h0c00, 16'h0010);
		chk({10'h000, txFsOe, txFsOut, txFsyncInt, rxFsOe, rxFsOut, rxFsyncInt},
			16'h003f);
		cfg(16'h0c04, 16'h0000);
		chk({10'h000, txFsOe, txFsOut, txFsyncInt, rxFsOe, rxFsOut, rxFsyncInt},
			16'h0025);
		cfg(16'h0c04, 16'h0008);
		chk({14'h0000, rxFsOe, rxFsyncInt}, 16'h0001);
		$display("test frame sync done");
		cfg(16'h0000, 16'h0000);
		runTx = 1'b1;
		runRx = 1'b1;
		st(40);
		for (m = 0; m < 2; m++)
		begin
			edgeChk = 1'b1;
			win(400);
			edgeChk = 1'b0;
			inr(tc, 49, 51);
			inr(rc, 49, 51);
			cfg(16'h0003, 16'h0000);
			txPol = 1'b1;
			rxPol = 1'b1;
			st(16);
		end
		$display("test link clocks done");
		genRun = 1'b1;
		cfg(16'h0300, 16'h0000);
		chk({14'h0000, txCkOe, rxCkOe}, 16'h0003);
		win(400);
		inr(tc, 39, 41);
		inr(rc, 39, 41);
		inr(cyc - txRise, 0, 12);
		inr(cyc - rxRise, 0, 12);
		runRx = 1'b0;
		cfg(16'h0000, 16'h0004);
		chk({15'h0000, rxCkOe}, 16'h0000);
		win(400);
		inr(rc, 49, 51);
		inr(cyc - rxRise, 400, 12000);
		cfg(16'h0300, 16'h0004);
		chk({15'h0000, rxCkOe}, 16'h0001);
		win(400);
		inr(rc, 39, 41);
		inr(cyc - rxRise, 0, 12);
		$display("test loopback done");
		for (m = 1; m < 4; m++)
		begin
			cfg(16'h0000, 16'(m));
			chk({15'h0000, txCkOe}, 16'h0000);
			win(400);
			inr(rc, 49, 51);
			cfg(16'h0200, 16'(m));
			chk({15'h0000, txCkOe}, 16'h0001);
			win(400);
			inr(rc, 39, 41);
			inr(cyc - txRise, 0, 12);
		end
		$display("test spi done");
		test_done;
	end
endmodule // testbench
